// *** inc/ref_ctrl_pkg.sv ***
// package: offsets, field positions, reset values and carriers for the reference/offset bank
// assumes an 8-bit sfr bus with single-cycle write strobe and combinational read
package ref_ctrl_pkg;
    localparam logic [7:0] ADDR_TEMP_OFFSET_LOW = 8'h85;
    localparam logic [7:0] ADDR_TEMP_OFFSET_HIGH = 8'h86;
    localparam logic [7:0] ADDR_REGULATOR_CONTROL = 8'hc7;
    localparam logic [7:0] ADDR_REFERENCE_CONTROL = 8'hd1;
    localparam int BIT_TEMP_SENSOR_ON = 2;
    localparam int BIT_REF_SOURCE_SELECT = 3;
    localparam int BIT_REGULATOR_REF_OVERRIDE = 4;
    localparam int BIT_STOP_REGULATOR_SHUTDOWN = 7;
    localparam int BIT_REGULATOR_BYPASS = 6;
    localparam int BIT_MEM_POWER_CTRL = 0;
    localparam logic [7:0] REFERENCE_CONTROL_WMASK = 8'h1c;
    localparam logic [7:0] REGULATOR_CONTROL_WMASK = 8'hc1;
    localparam logic [7:0] TEMP_OFFSET_LOW_WMASK = 8'hc0;
    localparam logic [7:0] REFERENCE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] REGULATOR_CONTROL_RESET = 8'h00;
    localparam logic [4:0] ADC_MUX_TEMP_SENSOR = 5'h1e;
    localparam logic [9:0] FACTORY_ZERO_C_DEFAULT = 10'h200;

    typedef enum logic [2:0] {
        VREF_EXT_PIN = 3'h1,
        VREF_VDD = 3'h2,
        VREF_REGULATOR = 3'h4
    } vref_source_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        vref_source_t vref_source;
        logic temp_sensor_on;
        logic temp_sensor_hiz;
        logic temp_to_adc;
    } analog_ctrl_t;

    typedef struct packed {
        logic regulator_on;
        logic power_network_on;
        logic reset_pin_only;
        logic regulator_bypass;
        logic mem_power_ctrl;
    } power_ctrl_t;
endpackage

// *** src/temp_offset_and_vref_control.sv ***
// register bank for adc reference select, temp sensor enable, factory offset and regulator control
// assumes sfr bus signals synchronous to core_clk; factory_zero_c_value is stable from power-up
`timescale 1ns/10ps
module temp_offset_and_vref_control
(
    input wire logic core_clk, // system clock, 40 MHz
    input wire logic arst_n, // async reset, active low
    input wire ref_ctrl_pkg::sfr_req_t sfr_req, // sfr write strobe, address, write data
    output logic [7:0] sfr_rdata, // read data for sfr_req.addr
    output logic sfr_hit, // address belongs to this bank
    input wire logic [9:0] factory_zero_c_value, // production-trimmed 0 C reading
    input wire logic [4:0] adc_positive_input_select, // adc positive mux code
    input wire logic stop_mode, // device in stop mode
    output ref_ctrl_pkg::analog_ctrl_t analog_ctrl, // reference and sensor controls
    output ref_ctrl_pkg::power_ctrl_t power_ctrl // regulator controls
);

    // --------------------------------------------------
    // register storage
    // --------------------------------------------------
    logic [7:0] reference_control_q;
    logic [7:0] regulator_control_q;
    logic [7:0] temp_offset_high_q;
    logic [7:0] temp_offset_low_q;
    logic load_pending_q;
    logic wr_ref, wr_reg, wr_hi, wr_lo;

    assign wr_ref = sfr_req.wr && (sfr_req.addr == ref_ctrl_pkg::ADDR_REFERENCE_CONTROL);
    assign wr_reg = sfr_req.wr && (sfr_req.addr == ref_ctrl_pkg::ADDR_REGULATOR_CONTROL);
    assign wr_hi = sfr_req.wr && (sfr_req.addr == ref_ctrl_pkg::ADDR_TEMP_OFFSET_HIGH);
    assign wr_lo = sfr_req.wr && (sfr_req.addr == ref_ctrl_pkg::ADDR_TEMP_OFFSET_LOW);

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            reference_control_q <= ref_ctrl_pkg::REFERENCE_CONTROL_RESET;
        else if (wr_ref)
            reference_control_q <= sfr_req.wdata & ref_ctrl_pkg::REFERENCE_CONTROL_WMASK;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            regulator_control_q <= ref_ctrl_pkg::REGULATOR_CONTROL_RESET;
        else if (wr_reg)
            regulator_control_q <= sfr_req.wdata & ref_ctrl_pkg::REGULATOR_CONTROL_WMASK;
    end

    // flag set by reset, used on first clock to capture the trim value
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            load_pending_q <= 1'b1;
        else
            load_pending_q <= 1'b0;
    end

    // offset bytes: reset constant, then factory value at the first edge after release
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            temp_offset_high_q <= ref_ctrl_pkg::FACTORY_ZERO_C_DEFAULT[9:2];
            temp_offset_low_q <= {ref_ctrl_pkg::FACTORY_ZERO_C_DEFAULT[1:0], 6'h00};
        end
        else if (load_pending_q)
        begin
            temp_offset_high_q <= factory_zero_c_value[9:2];
            temp_offset_low_q <= {factory_zero_c_value[1:0], 6'h00};
        end
        else
        begin
            if (wr_hi)
                temp_offset_high_q <= sfr_req.wdata;
            if (wr_lo)
                temp_offset_low_q <= sfr_req.wdata & ref_ctrl_pkg::TEMP_OFFSET_LOW_WMASK;
        end
    end

    // --------------------------------------------------
    // read mux
    // --------------------------------------------------
    always_comb
    begin
        sfr_hit = 1'b1;
        case (sfr_req.addr)
            ref_ctrl_pkg::ADDR_REFERENCE_CONTROL: sfr_rdata = reference_control_q;
            ref_ctrl_pkg::ADDR_REGULATOR_CONTROL: sfr_rdata = regulator_control_q;
            ref_ctrl_pkg::ADDR_TEMP_OFFSET_HIGH: sfr_rdata = temp_offset_high_q;
            ref_ctrl_pkg::ADDR_TEMP_OFFSET_LOW: sfr_rdata = temp_offset_low_q;
            default:
            begin
                sfr_rdata = 8'h00;
                sfr_hit = 1'b0;
            end
        endcase
    end

    // --------------------------------------------------
    // analog and power controls
    // --------------------------------------------------
    logic sensor_on, ovr, refsel, stop_regulator_shutdown, bypass;
    assign sensor_on = reference_control_q[ref_ctrl_pkg::BIT_TEMP_SENSOR_ON];
    assign ovr = reference_control_q[ref_ctrl_pkg::BIT_REGULATOR_REF_OVERRIDE];
    assign refsel = reference_control_q[ref_ctrl_pkg::BIT_REF_SOURCE_SELECT];
    assign stop_regulator_shutdown = regulator_control_q[ref_ctrl_pkg::BIT_STOP_REGULATOR_SHUTDOWN];
    assign bypass = regulator_control_q[ref_ctrl_pkg::BIT_REGULATOR_BYPASS];

    always_comb
    begin
        analog_ctrl.temp_sensor_on = sensor_on;
        analog_ctrl.temp_sensor_hiz = !sensor_on;
        analog_ctrl.temp_to_adc = (adc_positive_input_select == ref_ctrl_pkg::ADC_MUX_TEMP_SENSOR);
        if (ovr)
            analog_ctrl.vref_source = ref_ctrl_pkg::VREF_REGULATOR;
        else if (refsel)
            analog_ctrl.vref_source = ref_ctrl_pkg::VREF_VDD;
        else
            analog_ctrl.vref_source = ref_ctrl_pkg::VREF_EXT_PIN;
    end

    always_comb
    begin
        power_ctrl.regulator_bypass = bypass;
        power_ctrl.regulator_on = !bypass && !(stop_mode && stop_regulator_shutdown);
        power_ctrl.power_network_on = !(stop_mode && stop_regulator_shutdown);
        power_ctrl.reset_pin_only = stop_mode && stop_regulator_shutdown;
        power_ctrl.mem_power_ctrl = regulator_control_q[ref_ctrl_pkg::BIT_MEM_POWER_CTRL];
    end

    // --------------------------------------------------
    // assertions
    // --------------------------------------------------
    a_ref_reserved_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
        (reference_control_q & ~ref_ctrl_pkg::REFERENCE_CONTROL_WMASK) == 8'h00)
        else $error("reserved reference bits set");
    a_low_reserved_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
        temp_offset_low_q[5:0] == 6'h00)
        else $error("reserved offset low bits set");
    a_ref_write_update: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_ref |=> reference_control_q == ($past(sfr_req.wdata) & ref_ctrl_pkg::REFERENCE_CONTROL_WMASK))
        else $error("reference write not applied");
    a_ref_hold_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
        !wr_ref |=> $stable(reference_control_q))
        else $error("reference changed without write");
    a_offset_load_after: assert property (@(posedge core_clk) disable iff (!arst_n)
        load_pending_q |=> temp_offset_high_q == $past(factory_zero_c_value[9:2])
            && temp_offset_low_q[7:6] == $past(factory_zero_c_value[1:0]))
        else $error("factory offset not loaded");
    a_vref_override_wins: assert property (@(posedge core_clk) disable iff (!arst_n)
        ovr |-> analog_ctrl.vref_source == ref_ctrl_pkg::VREF_REGULATOR)
        else $error("override did not select regulator");
    a_vref_select_pin: assert property (@(posedge core_clk) disable iff (!arst_n)
        (wr_ref && sfr_req.wdata[4:3] == 2'b00) |=> analog_ctrl.vref_source == ref_ctrl_pkg::VREF_EXT_PIN)
        else $error("pin reference not selected");
    a_sensor_follow_bit: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_ref |=> analog_ctrl.temp_sensor_on == $past(sfr_req.wdata[2])
            && analog_ctrl.temp_sensor_hiz != analog_ctrl.temp_sensor_on)
        else $error("sensor enable mismatch");
    a_stop_shutdown: assert property (@(posedge core_clk) disable iff (!arst_n)
        (stop_mode && stop_regulator_shutdown) |-> !power_ctrl.regulator_on && !power_ctrl.power_network_on)
        else $error("regulator on in stop with shutdown");
    a_stop_default_on: assert property (@(posedge core_clk) disable iff (!arst_n)
        (stop_mode && !stop_regulator_shutdown && !bypass) |-> power_ctrl.regulator_on && !power_ctrl.reset_pin_only)
        else $error("regulator off in default stop");
    a_ref_vdd_select: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!ovr && refsel) |-> analog_ctrl.vref_source == ref_ctrl_pkg::VREF_VDD)
        else $error("supply reference not selected");
    a_ref_pin_default: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!ovr && !refsel) |-> analog_ctrl.vref_source == ref_ctrl_pkg::VREF_EXT_PIN)
        else $error("pin reference not held");
    a_sensor_off_hiz: assert property (@(posedge core_clk) disable iff (!arst_n)
        !sensor_on |-> analog_ctrl.temp_sensor_hiz && !analog_ctrl.temp_sensor_on)
        else $error("disabled sensor not high impedance");
    a_mux_temp_route: assert property (@(posedge core_clk) disable iff (!arst_n)
        analog_ctrl.temp_to_adc == (adc_positive_input_select == ref_ctrl_pkg::ADC_MUX_TEMP_SENSOR))
        else $error("sensor routing mismatch");
    a_reg_write_update: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_reg |=> regulator_control_q == ($past(sfr_req.wdata) & ref_ctrl_pkg::REGULATOR_CONTROL_WMASK))
        else $error("regulator write not applied");
    a_reg_hold_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
        !wr_reg |=> $stable(regulator_control_q))
        else $error("regulator control changed without write");
    a_reg_reserved_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
        (regulator_control_q & ~ref_ctrl_pkg::REGULATOR_CONTROL_WMASK) == 8'h00)
        else $error("reserved regulator bits set");
    a_low_write_update: assert property (@(posedge core_clk) disable iff (!arst_n)
        (wr_lo && !load_pending_q) |=> temp_offset_low_q
            == ($past(sfr_req.wdata) & ref_ctrl_pkg::TEMP_OFFSET_LOW_WMASK))
        else $error("offset low write not applied");
    a_high_write_update: assert property (@(posedge core_clk) disable iff (!arst_n)
        (wr_hi && !load_pending_q) |=> temp_offset_high_q == $past(sfr_req.wdata))
        else $error("offset high write not applied");
    a_offset_hold_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!wr_hi && !wr_lo && !load_pending_q) |=> $stable(temp_offset_high_q) && $stable(temp_offset_low_q))
        else $error("offset changed without write");
    a_bypass_reg_off: assert property (@(posedge core_clk) disable iff (!arst_n)
        bypass |-> !power_ctrl.regulator_on && power_ctrl.regulator_bypass)
        else $error("regulator on in bypass");
    a_shutdown_needs_stop: assert property (@(posedge core_clk) disable iff (!arst_n)
        power_ctrl.reset_pin_only |-> stop_mode && stop_regulator_shutdown)
        else $error("reset pin only outside stop shutdown");
    a_awake_network_on: assert property (@(posedge core_clk) disable iff (!arst_n)
        !stop_mode |-> power_ctrl.power_network_on && !power_ctrl.reset_pin_only)
        else $error("power network off while awake");
    c_sensor_measure: cover property (@(posedge core_clk) disable iff (!arst_n)
        sensor_on && analog_ctrl.temp_to_adc);
    c_override_used: cover property (@(posedge core_clk) disable iff (!arst_n) ovr && refsel);
    c_stop_shutdown: cover property (@(posedge core_clk) disable iff (!arst_n) stop_mode && stop_regulator_shutdown);
    c_bypass_used: cover property (@(posedge core_clk) disable iff (!arst_n) bypass && !power_ctrl.regulator_on);
    c_offset_written: cover property (@(posedge core_clk) disable iff (!arst_n) wr_lo && !load_pending_q);
endmodule // temp_offset_and_vref_control

// *** verification/test_temp_offset_and_vref_control.sv ***
// self-checking bench for the reference/offset register bank
// assumes ref_ctrl_pkg compiled first; bench drives the sfr bus itself
`timescale 1ns/10ps
module test_temp_offset_and_vref_control;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    ref_ctrl_pkg::sfr_req_t sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic sfr_hit;
    logic [9:0] factory_zero_c_value = 10'h2b7;
    logic [4:0] adc_positive_input_select = 5'h00;
    logic stop_mode = 1'b0;
    ref_ctrl_pkg::analog_ctrl_t analog_ctrl;
    ref_ctrl_pkg::power_ctrl_t power_ctrl;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] rd;
    logic [7:0] wr_tbl [5] = '{8'hff, 8'h08, 8'h10, 8'h04, 8'he3};

    temp_offset_and_vref_control i_temp_offset_and_vref_control (.core_clk(core_clk), .arst_n(arst_n),
        .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .factory_zero_c_value(factory_zero_c_value),
        .adc_positive_input_select(adc_positive_input_select), .stop_mode(stop_mode),
        .analog_ctrl(analog_ctrl), .power_ctrl(power_ctrl));

    // ----------------------------------------
    // clock, bus tasks, checking
    // ----------------------------------------
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        #1;
        sfr_req = {1'b1, addr, data};
        @(posedge core_clk);
        #1;
        sfr_req.wr = 1'b0;
    endtask

    task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
        sfr_req.addr = addr;
        #2;
        data = sfr_rdata;
    endtask

    task automatic print_verdict();
        $display("n_mismatch %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        repeat (9) @(posedge core_clk);
        #1;
        sfr_read(ref_ctrl_pkg::ADDR_TEMP_OFFSET_HIGH, rd);
        check("offset_high_in_reset", rd, ref_ctrl_pkg::FACTORY_ZERO_C_DEFAULT[9:2]);
        @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        sfr_read(ref_ctrl_pkg::ADDR_TEMP_OFFSET_HIGH, rd);
        check("offset_high", rd, factory_zero_c_value[9:2]);
        sfr_read(ref_ctrl_pkg::ADDR_TEMP_OFFSET_LOW, rd);
        check("offset_low", rd, {factory_zero_c_value[1:0], 6'h00});
        sfr_read(ref_ctrl_pkg::ADDR_REFERENCE_CONTROL, rd);
        check("reference_control", rd, 8'h00);
        sfr_read(ref_ctrl_pkg::ADDR_REGULATOR_CONTROL, rd);
        check("regulator_control", rd, 8'h00);
    endtask

    task automatic t_refctrl();
        foreach (wr_tbl[i])
        begin
            sfr_write(ref_ctrl_pkg::ADDR_REFERENCE_CONTROL, wr_tbl[i]);
            sfr_read(ref_ctrl_pkg::ADDR_REFERENCE_CONTROL, rd);
            check("reference_control", rd, wr_tbl[i] & 8'h1c);
            check("vref_source", {5'h00, analog_ctrl.vref_source},
                wr_tbl[i][4] ? 8'h04 : (wr_tbl[i][3] ? 8'h02 : 8'h01));
            check("temp_sensor_on", {7'h00, analog_ctrl.temp_sensor_on}, {7'h00, wr_tbl[i][2]});
            check("temp_sensor_hiz", {7'h00, analog_ctrl.temp_sensor_hiz}, {7'h00, !wr_tbl[i][2]});
        end
    endtask

    task automatic t_offset();
        sfr_write(ref_ctrl_pkg::ADDR_TEMP_OFFSET_LOW, 8'hff);
        sfr_write(ref_ctrl_pkg::ADDR_TEMP_OFFSET_HIGH, 8'h5a);
        sfr_read(ref_ctrl_pkg::ADDR_TEMP_OFFSET_LOW, rd);
        check("offset_low", rd, 8'hc0);
        sfr_write(ref_ctrl_pkg::ADDR_TEMP_OFFSET_LOW, 8'h3f);
        sfr_read(ref_ctrl_pkg::ADDR_TEMP_OFFSET_LOW, rd);
        check("offset_low", rd, 8'h00);
        sfr_read(ref_ctrl_pkg::ADDR_TEMP_OFFSET_HIGH, rd);
        check("offset_high", rd, 8'h5a);
    endtask

    task automatic t_regulator();
        sfr_write(ref_ctrl_pkg::ADDR_REGULATOR_CONTROL, 8'hc1);
        sfr_read(ref_ctrl_pkg::ADDR_REGULATOR_CONTROL, rd);
        check("regulator_control", rd, 8'hc1);
        check("bypass", {7'h00, power_ctrl.regulator_bypass}, 8'h01);
        check("bypass_regulator_off", {7'h00, power_ctrl.regulator_on}, 8'h00);
        check("mem_power_ctrl", {7'h00, power_ctrl.mem_power_ctrl}, 8'h01);
        sfr_write(ref_ctrl_pkg::ADDR_REGULATOR_CONTROL, 8'h80);
        check("regulator_on", {7'h00, power_ctrl.regulator_on}, 8'h01);
        stop_mode = 1'b1;
        #2;
        check("stop_shutdown", {6'h00, power_ctrl.regulator_on, power_ctrl.power_network_on}, 8'h00);
        check("reset_pin_only", {7'h00, power_ctrl.reset_pin_only}, 8'h01);
        sfr_write(ref_ctrl_pkg::ADDR_REGULATOR_CONTROL, 8'h00);
        check("stop_default", {6'h00, power_ctrl.regulator_on, power_ctrl.power_network_on}, 8'h03);
        check("reset_pin_only", {7'h00, power_ctrl.reset_pin_only}, 8'h00);
        stop_mode = 1'b0;
    endtask

    task automatic t_reload();
        sfr_write(ref_ctrl_pkg::ADDR_REFERENCE_CONTROL, 8'h1c);
        arst_n = 1'b0;
        factory_zero_c_value = 10'h0c5;
        @(posedge core_clk);
        #1;
        sfr_read(ref_ctrl_pkg::ADDR_REFERENCE_CONTROL, rd);
        check("reference_control_reset", rd, ref_ctrl_pkg::REFERENCE_CONTROL_RESET);
        @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        @(posedge core_clk);
        #1;
        sfr_read(ref_ctrl_pkg::ADDR_TEMP_OFFSET_HIGH, rd);
        check("offset_high_reload", rd, 8'h31);
        sfr_read(ref_ctrl_pkg::ADDR_TEMP_OFFSET_LOW, rd);
        check("offset_low_reload", rd, 8'h40);
    endtask

    task automatic t_mux_unmapped();
        sfr_write(ref_ctrl_pkg::ADDR_REFERENCE_CONTROL, 8'h04);
        adc_positive_input_select = 5'h1e;
        #2 check("temp_to_adc", {7'h00, analog_ctrl.temp_to_adc}, 8'h01);
        adc_positive_input_select = 5'h1f;
        #2 check("temp_to_adc", {7'h00, analog_ctrl.temp_to_adc}, 8'h00);
        sfr_write(8'h84, 8'hff);
        sfr_read(8'h84, rd);
        check("unmapped_rdata", rd, 8'h00);
        check("unmapped_hit", {7'h00, sfr_hit}, 8'h00);
        sfr_read(ref_ctrl_pkg::ADDR_REFERENCE_CONTROL, rd);
        check("reference_control", rd, 8'h04);
        check("reference_hit", {7'h00, sfr_hit}, 8'h01);
    endtask

    initial
    begin
        t_reset();
        t_refctrl();
        t_offset();
        t_regulator();
        t_reload();
        t_mux_unmapped();
        print_verdict();
    end
endmodule // test_temp_offset_and_vref_control
